// ### hdl/mdi_scan_vote.sv
/*
 * Top of the monitored input block: triplicated-leg APB slave with voter
 * and three independent read drivers, status decode, test control and
 * front panel indicators.
 * Assumes three processor legs share psel/penable timing and pclk, and
 * that comparator, reference monitor and supply pins are asynchronous.
 */
// Implementation choices: the APB register port and the placing of the registers.
// Summary of operation
// - Vote address, direction and data of three legs; registers use only the vote, leg mismatch and voter check see raw legs.
// - Each of three read drivers loads and enables independently.
// - Leg disagreement is outvoted; voter self-check failure sets fault.
// - A fixed identification word is readable.
// - Loopback register returns last written word.
// - Sequencer drives DAC and samples sixteen comparators.
// - Reference visits three thresholds each sweep; all are captured.
// - Per point on/off and line fault derive from three captures.
// - Test request adds stuck-on and stuck-off reference levels.
// - Test comparator words and reference readings are readable.
// - Processor-reported input fault lights the fault indicator.
// - Without fault, activity indicator toggles every sweep.
// - Module fault lights red and forces green off.
// - Power indicator shows field voltage and regulator health.
// - Yellow lights on switch closed or wire short.
// - Red line lights on open or short, unless disabled.
// - Threshold defaults 20 V, 12 V, 4 V; all writable.
// - Four states decode from open, on/off, short comparisons.
// - Point one is bit zero, point sixteen bit fifteen.
`timescale 1ns/1ps
`include "mdi_scan_regs.svh"

module mdi_scan_vote
	import mdi_pkg::*;
#(
	parameter logic [31:0] ID_CODE = `MDI_ID_DEFAULT // Arbitrary value
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic [7:0]  paddr_a,
	input  wire logic [7:0]  paddr_b,
	input  wire logic [7:0]  paddr_c,
	input  wire logic        pwrite_a,
	input  wire logic        pwrite_b,
	input  wire logic        pwrite_c,
	input  wire logic [31:0] pwdata_a,
	input  wire logic [31:0] pwdata_b,
	input  wire logic [31:0] pwdata_c,
	output logic      [31:0] prdata_a,
	output logic      [31:0] prdata_b,
	output logic      [31:0] prdata_c,
	output logic             drv_en_a,
	output logic             drv_en_b,
	output logic             drv_en_c,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [15:0] cmp_pin,
	input  wire logic [7:0]  ref_pin,
	input  wire logic        field_pwr_pin,
	input  wire logic        reg_ok_pin,
	output logic      [7:0]  dac_code,
	output logic      [15:0] led_yellow,
	output logic      [15:0] led_line,
	output logic             led_active,
	output logic             led_fault,
	output logic             led_power
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [31:0] v_addr_w;
	logic [31:0] v_data;
	logic [31:0] v_wr_w;
	logic [31:0] v_chk;
	logic [7:0]  v_addr;
	logic        v_write;
	logic        setup;
	logic        xfer;
	logic        mapped;
	logic [31:0] rd_word;
	logic        test_req_ff;
	logic        ldis_ff;
	logic        pflt_ff;
	logic [2:0]  drv_off_ff;
	logic        tdone_ff;
	logic        vflt_ff;
	logic        legmis_ff;
	logic        mflt;
	logic [31:0] loop_ff;
	logic [31:0] thr_ff;
	logic [15:0] in_on_ff;
	logic [15:0] line_flt_ff;
	logic [15:0] nxt_on;
	logic [15:0] nxt_flt;
	logic [15:0] f_open;
	logic [15:0] f_onoff;
	logic [15:0] f_short;
	logic [15:0] f_hi;
	logic [15:0] f_lo;
	logic [7:0]  f_ref_hi;
	logic [7:0]  f_ref_lo;
	logic        f_sweep;
	logic        f_tdone;
	logic        pwr_s1_ff;
	logic        pwr_s2_ff;
	logic        rok_s1_ff;
	logic        rok_s2_ff;
	logic        wr_ctrl;
	logic        wr_stat;

	// Bitwise two-of-three majority
	function automatic logic [31:0] maj3(input logic [31:0] a,
		input logic [31:0] b, input logic [31:0] c);
		maj3 = (a & b) | (b & c) | (a & c);
	endfunction : maj3

	// ------------------------------------------------------------------
	// Voter
	// ------------------------------------------------------------------
	// A single bad leg is outvoted, so reads never depend on one leg
	assign v_addr_w = maj3({24'h00_0000, paddr_a}, {24'h00_0000, paddr_b},
		{24'h00_0000, paddr_c});
	assign v_wr_w   = maj3({31'h0000_0000, pwrite_a},
		{31'h0000_0000, pwrite_b}, {31'h0000_0000, pwrite_c});
	assign v_data   = maj3(pwdata_a, pwdata_b, pwdata_c);
	assign v_addr   = v_addr_w[7:0];
	assign v_write  = v_wr_w[0];
	// Second voter built differently; a mismatch means voter hardware fault
	assign v_chk    = (pwdata_a & pwdata_b) ^ (pwdata_a & pwdata_c) ^
		(pwdata_b & pwdata_c);

	assign setup   = psel && !penable;
	assign xfer    = psel && penable && pready;
	assign wr_ctrl = xfer && v_write && (v_addr == `MDI_REG_CTRL);
	assign wr_stat = xfer && v_write && (v_addr == `MDI_REG_STATUS);
	assign mflt    = vflt_ff || pflt_ff;

	// ------------------------------------------------------------------
	// Read decode
	// ------------------------------------------------------------------
	always_comb begin
		mapped  = 1'b1;
		rd_word = 32'h0000_0000;
		case (v_addr)
			`MDI_REG_ID:     rd_word = ID_CODE;
			`MDI_REG_CTRL:   begin
				rd_word[`MDI_CTRL_TEST]  = test_req_ff;
				rd_word[`MDI_CTRL_LDIS]  = ldis_ff;
				rd_word[`MDI_CTRL_PFLT]  = pflt_ff;
				rd_word[`MDI_CTRL_DRV_A] = drv_off_ff[0];
				rd_word[`MDI_CTRL_DRV_B] = drv_off_ff[1];
				rd_word[`MDI_CTRL_DRV_C] = drv_off_ff[2];
			end
			`MDI_REG_STATUS: begin
				rd_word[`MDI_STAT_BUSY]   = test_req_ff;
				rd_word[`MDI_STAT_TDONE]  = tdone_ff;
				rd_word[`MDI_STAT_VFLT]   = vflt_ff;
				rd_word[`MDI_STAT_LEGMIS] = legmis_ff;
				rd_word[`MDI_STAT_MFLT]   = mflt;
			end
			`MDI_REG_LOOP:   rd_word = loop_ff;
			`MDI_REG_THRESH: rd_word = thr_ff;
			`MDI_REG_INPUT:  rd_word = {16'h0000, in_on_ff};
			`MDI_REG_LINE:   rd_word = {16'h0000, line_flt_ff};
			`MDI_REG_TCMP:   rd_word = {f_lo, f_hi};
			`MDI_REG_TREF:   rd_word = {16'h0000, f_ref_lo, f_ref_hi};
			default:         mapped = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------
	// Bus handshake: answer in the first access cycle
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup && !mapped;
		end
	end

	// Three drivers, each with its own enable and data flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_a <= 32'h0000_0000;
			prdata_b <= 32'h0000_0000;
			prdata_c <= 32'h0000_0000;
			drv_en_a <= 1'b0;
			drv_en_b <= 1'b0;
			drv_en_c <= 1'b0;
		end else if (setup && !v_write) begin
			drv_en_a <= !drv_off_ff[0];
			drv_en_b <= !drv_off_ff[1];
			drv_en_c <= !drv_off_ff[2];
			prdata_a <= drv_off_ff[0] ? 32'h0000_0000 : rd_word;
			prdata_b <= drv_off_ff[1] ? 32'h0000_0000 : rd_word;
			prdata_c <= drv_off_ff[2] ? 32'h0000_0000 : rd_word;
		end
	end

	// ------------------------------------------------------------------
	// Control and configuration registers
	// ------------------------------------------------------------------
	// Test request clears when the test completes; a new request wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			test_req_ff <= 1'b0;
			ldis_ff     <= 1'b0;
			pflt_ff     <= 1'b0;
			drv_off_ff  <= 3'h0;
		end else begin
			if (wr_ctrl && v_data[`MDI_CTRL_TEST]) begin
				test_req_ff <= 1'b1;
			end else if (f_tdone) begin
				test_req_ff <= 1'b0;
			end
			if (wr_ctrl) begin
				ldis_ff       <= v_data[`MDI_CTRL_LDIS];
				pflt_ff       <= v_data[`MDI_CTRL_PFLT];
				drv_off_ff[0] <= v_data[`MDI_CTRL_DRV_A];
				drv_off_ff[1] <= v_data[`MDI_CTRL_DRV_B];
				drv_off_ff[2] <= v_data[`MDI_CTRL_DRV_C];
			end
		end
	end

	// Loopback and thresholds
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_ff <= `MDI_LOOP_RESET;
			thr_ff  <= `MDI_THR_RESET;
		end else if (xfer && v_write) begin
			if (v_addr == `MDI_REG_LOOP) begin
				loop_ff <= v_data;
			end
			if (v_addr == `MDI_REG_THRESH) begin
				thr_ff <= {8'h00, v_data[23:0]};
			end
		end
	end

	// Sticky status: hardware set wins over a write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tdone_ff  <= 1'b0;
			vflt_ff   <= 1'b0;
			legmis_ff <= 1'b0;
		end else begin
			if (f_tdone) begin
				tdone_ff <= 1'b1;
			end else if (wr_stat && v_data[`MDI_STAT_TDONE]) begin
				tdone_ff <= 1'b0;
			end
			if (xfer && (v_data != v_chk)) begin
				vflt_ff <= 1'b1;
			end else if (wr_stat && v_data[`MDI_STAT_VFLT]) begin
				vflt_ff <= 1'b0;
			end
			if (xfer && ((paddr_a != paddr_b) || (paddr_b != paddr_c) ||
				(pwdata_a != pwdata_b) || (pwdata_b != pwdata_c))) begin
				legmis_ff <= 1'b1;
			end else if (wr_stat && v_data[`MDI_STAT_LEGMIS]) begin
				legmis_ff <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Field sequencer
	// ------------------------------------------------------------------
	mdi_field_seq u_seq (
		.pclk          (pclk),
		.presetn       (presetn),
		.thr_open      (thr_ff[7:0]),
		.thr_onoff     (thr_ff[15:8]),
		.thr_short     (thr_ff[23:16]),
		.test_req      (test_req_ff),
		.cmp_pin       (cmp_pin),
		.ref_pin       (ref_pin),
		.dac_ff        (dac_code),
		.open_ff       (f_open),
		.onoff_ff      (f_onoff),
		.short_ff      (f_short),
		.test_hi_ff    (f_hi),
		.test_lo_ff    (f_lo),
		.ref_hi_ff     (f_ref_hi),
		.ref_lo_ff     (f_ref_lo),
		.sweep_done_ff (f_sweep),
		.test_done_ff  (f_tdone)
	);

	// Comparator high means input above reference
	assign nxt_on  = ~f_onoff;
	assign nxt_flt = f_open | ~f_short;

	// Status words refresh only on a finished sweep
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_on_ff    <= 16'h0000;
			line_flt_ff <= 16'h0000;
		end else if (f_sweep) begin
			in_on_ff    <= nxt_on;
			line_flt_ff <= nxt_flt;
		end
	end

	// ------------------------------------------------------------------
	// Front panel
	// ------------------------------------------------------------------
	// Supply pins are asynchronous, so sync before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_s1_ff <= 1'b0;
			pwr_s2_ff <= 1'b0;
			rok_s1_ff <= 1'b0;
			rok_s2_ff <= 1'b0;
			led_power <= 1'b0;
		end else begin
			pwr_s1_ff <= field_pwr_pin;
			pwr_s2_ff <= pwr_s1_ff;
			rok_s1_ff <= reg_ok_pin;
			rok_s2_ff <= rok_s1_ff;
			led_power <= pwr_s2_ff && rok_s2_ff;
		end
	end

	// Point indicators follow the published status words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_yellow <= 16'h0000;
			led_line   <= 16'h0000;
		end else begin
			led_yellow <= in_on_ff;
			led_line   <= ldis_ff ? 16'h0000 : line_flt_ff;
		end
	end

	// Activity blinks at scan rate; a module fault (voter or processor-reported) kills it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_active <= 1'b0;
			led_fault  <= 1'b0;
		end else begin
			led_fault <= mflt;
			if (mflt) begin
				led_active <= 1'b0;
			end else if (f_sweep) begin
				led_active <= !led_active;
			end
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	property p_id_read;
		@(posedge pclk) disable iff (!presetn)
		(setup && !v_write && v_addr == `MDI_REG_ID && !drv_off_ff[1])
			|=> (prdata_b == ID_CODE) && drv_en_b;
	endproperty
	a_id_read: assert property (p_id_read)
		else $error("Voted ID read not returned");

	property p_drv_indep;
		@(posedge pclk) disable iff (!presetn)
		(setup && !v_write) |=>
			(drv_en_a == !$past(drv_off_ff[0])) &&
			(drv_en_c == !$past(drv_off_ff[2]));
	endproperty
	a_drv_indep: assert property (p_drv_indep)
		else $error("Driver enable not independent");

	property p_leg_mis;
		@(posedge pclk) disable iff (!presetn)
		(xfer && paddr_a != paddr_b) |=> legmis_ff;
	endproperty
	a_leg_mis: assert property (p_leg_mis)
		else $error("Leg discrepancy not recorded");

	property p_loop;
		@(posedge pclk) disable iff (!presetn)
		(xfer && v_write && v_addr == `MDI_REG_LOOP) |=>
			loop_ff == $past(v_data);
	endproperty
	a_loop: assert property (p_loop)
		else $error("Loopback word not stored");

	property p_sweep;
		@(posedge pclk) disable iff (!presetn)
		f_sweep |=> (in_on_ff == ~$past(f_onoff)) &&
			(line_flt_ff == ($past(f_open) | ~$past(f_short)));
	endproperty
	a_sweep: assert property (p_sweep)
		else $error("Status words not updated from sweep");

	property p_fault_led;
		@(posedge pclk) disable iff (!presetn)
		mflt |=> led_fault && !led_active;
	endproperty
	a_fault_led: assert property (p_fault_led)
		else $error("Fault indicators wrong");

	property p_blink;
		@(posedge pclk) disable iff (!presetn)
		(f_sweep && !mflt) |=> led_active != $past(led_active);
	endproperty
	a_blink: assert property (p_blink)
		else $error("Activity indicator did not toggle");

	property p_line_dis;
		@(posedge pclk) disable iff (!presetn)
		ldis_ff |=> led_line == 16'h0000;
	endproperty
	a_line_dis: assert property (p_line_dis)
		else $error("Line indicator not disabled");

endmodule : mdi_scan_vote

// ### hdl/mdi_scan_regs.svh
/*
 * Register map, field positions, reset values and timing constants of the
 * monitored input scan and vote block.
 * Assumes a 50 MHz pclk and an 8-bit reference DAC whose code is
 * (volts + 8) * 4, so that -8 V is code zero.
 */
`ifndef MDI_SCAN_REGS_SVH
`define MDI_SCAN_REGS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define MDI_REG_ID      8'h00
`define MDI_REG_CTRL    8'h04
`define MDI_REG_STATUS  8'h08
`define MDI_REG_LOOP    8'h0C
`define MDI_REG_THRESH  8'h10
`define MDI_REG_INPUT   8'h14
`define MDI_REG_LINE    8'h18
`define MDI_REG_TCMP    8'h1C
`define MDI_REG_TREF    8'h20

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MDI_CTRL_TEST   0
`define MDI_CTRL_LDIS   1
`define MDI_CTRL_PFLT   2
`define MDI_CTRL_DRV_A  4
`define MDI_CTRL_DRV_B  5
`define MDI_CTRL_DRV_C  6
`define MDI_STAT_BUSY   0
`define MDI_STAT_TDONE  1
`define MDI_STAT_VFLT   2
`define MDI_STAT_LEGMIS 3
`define MDI_STAT_MFLT   4

// ----------------------------------------------------------------------
// Reset values and DAC codes
// ----------------------------------------------------------------------
`define MDI_ID_DEFAULT  32'h0000_A5A5
`define MDI_THR_RESET   32'h0030_5070
`define MDI_LOOP_RESET  32'h0000_0000
`define MDI_DAC_TEST_HI 8'hA0
`define MDI_DAC_TEST_LO 8'h0C

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define MDI_CLK_NS      20
`define MDI_SETTLE_NS   10000
`define MDI_SETTLE_CYC  ((`MDI_SETTLE_NS + `MDI_CLK_NS - 1) / `MDI_CLK_NS)

`endif

// ### hdl/mdi_pkg.sv
/*
 * Types shared by the scan sequencer and the bus side of the block.
 * Assumes nothing of its surroundings.
 */
package mdi_pkg;

	// ------------------------------------------------------------------
	// Sequencer states and reference levels
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {SEQ_SET, SEQ_SETTLE, SEQ_SAMPLE} mdi_seq_e;
	typedef enum logic [2:0] {
		LVL_OPEN, LVL_ONOFF, LVL_SHORT, LVL_TEST_HI, LVL_TEST_LO
	} mdi_lvl_e;

endpackage : mdi_pkg

// ### hdl/mdi_field_seq.sv
/*
 * Field-side sequencer: steps the reference DAC through the three
 * thresholds, and through the two test levels when asked, and samples the
 * sixteen comparators at each level.
 * Assumes comparator and reference monitor pins are asynchronous to pclk.
 */
`timescale 1ns/1ps
`include "mdi_scan_regs.svh"

module mdi_field_seq
	import mdi_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  thr_open,
	input  wire logic [7:0]  thr_onoff,
	input  wire logic [7:0]  thr_short,
	input  wire logic        test_req,
	input  wire logic [15:0] cmp_pin,
	input  wire logic [7:0]  ref_pin,
	output logic      [7:0]  dac_ff,
	output logic      [15:0] open_ff,
	output logic      [15:0] onoff_ff,
	output logic      [15:0] short_ff,
	output logic      [15:0] test_hi_ff,
	output logic      [15:0] test_lo_ff,
	output logic      [7:0]  ref_hi_ff,
	output logic      [7:0]  ref_lo_ff,
	output logic             sweep_done_ff,
	output logic             test_done_ff
);

	localparam logic [9:0] SETTLE_LAST = 10'(`MDI_SETTLE_CYC - 1);

	mdi_seq_e    state_ff;
	mdi_lvl_e    lvl_ff;
	mdi_lvl_e    nxt_lvl;
	logic [9:0]  cnt_ff;
	logic [15:0] cmp_s1_ff;
	logic [15:0] cmp_s2_ff;
	logic [7:0]  ref_s1_ff;
	logic [7:0]  ref_s2_ff;
	logic [15:0] scr_open_ff;
	logic [15:0] scr_onoff_ff;

	// DAC code for each reference level
	function automatic logic [7:0] level_code(input mdi_lvl_e l);
		case (l)
			LVL_OPEN:    level_code = thr_open;
			LVL_ONOFF:   level_code = thr_onoff;
			LVL_SHORT:   level_code = thr_short;
			LVL_TEST_HI: level_code = `MDI_DAC_TEST_HI;
			default:     level_code = `MDI_DAC_TEST_LO;
		endcase
	endfunction : level_code

	// Pins cross into pclk through two flops each
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_s1_ff <= 16'h0000;
			cmp_s2_ff <= 16'h0000;
			ref_s1_ff <= 8'h00;
			ref_s2_ff <= 8'h00;
		end else begin
			cmp_s1_ff <= cmp_pin;
			cmp_s2_ff <= cmp_s1_ff;
			ref_s1_ff <= ref_pin;
			ref_s2_ff <= ref_s1_ff;
		end
	end

	// Level order: three thresholds, then test levels only on request
	always_comb begin
		case (lvl_ff)
			LVL_OPEN:    nxt_lvl = LVL_ONOFF;
			LVL_ONOFF:   nxt_lvl = LVL_SHORT;
			LVL_SHORT:   nxt_lvl = test_req ? LVL_TEST_HI : LVL_OPEN;
			LVL_TEST_HI: nxt_lvl = LVL_TEST_LO;
			default:     nxt_lvl = LVL_OPEN;
		endcase
	end

	// Set the DAC, wait for settling, then sample
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= SEQ_SET;
			lvl_ff   <= LVL_OPEN;
			cnt_ff   <= 10'h000;
			dac_ff   <= `MDI_DAC_TEST_LO;
		end else begin
			case (state_ff)
				SEQ_SET: begin
					dac_ff   <= level_code(lvl_ff);
					cnt_ff   <= 10'h000;
					state_ff <= SEQ_SETTLE;
				end
				SEQ_SETTLE: begin
					cnt_ff <= cnt_ff + 10'h001;
					if (cnt_ff == SETTLE_LAST) begin
						state_ff <= SEQ_SAMPLE;
					end
				end
				SEQ_SAMPLE: begin
					lvl_ff   <= nxt_lvl;
					state_ff <= SEQ_SET;
				end
				default: state_ff <= SEQ_SET;
			endcase
		end
	end

	// Captures; the three threshold words change only at the end of a sweep
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scr_open_ff  <= 16'h0000;
			scr_onoff_ff <= 16'h0000;
			open_ff      <= 16'h0000;
			onoff_ff     <= 16'h0000;
			short_ff     <= 16'h0000;
			test_hi_ff   <= 16'h0000;
			test_lo_ff   <= 16'h0000;
			ref_hi_ff    <= 8'h00;
			ref_lo_ff    <= 8'h00;
		end else if (state_ff == SEQ_SAMPLE) begin
			case (lvl_ff)
				LVL_OPEN:  scr_open_ff  <= cmp_s2_ff;
				LVL_ONOFF: scr_onoff_ff <= cmp_s2_ff;
				LVL_SHORT: begin
					open_ff  <= scr_open_ff;
					onoff_ff <= scr_onoff_ff;
					short_ff <= cmp_s2_ff;
				end
				LVL_TEST_HI: begin
					test_hi_ff <= cmp_s2_ff;
					ref_hi_ff  <= ref_s2_ff;
				end
				default: begin
					test_lo_ff <= cmp_s2_ff;
					ref_lo_ff  <= ref_s2_ff;
				end
			endcase
		end
	end

	// One-cycle completion pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sweep_done_ff <= 1'b0;
			test_done_ff  <= 1'b0;
		end else begin
			sweep_done_ff <= (state_ff == SEQ_SAMPLE) && (lvl_ff == LVL_SHORT);
			test_done_ff  <= (state_ff == SEQ_SAMPLE) &&
				(lvl_ff == LVL_TEST_LO);
		end
	end

	// DAC holds still while the comparators settle
	property p_dac_steady;
		@(posedge pclk) disable iff (!presetn)
		(state_ff == SEQ_SETTLE && cnt_ff != 10'h000) |-> $stable(dac_ff);
	endproperty
	a_dac_steady: assert property (p_dac_steady)
		else $error("DAC moved during settling");

	// Test-high level drives the stuck-on code
	property p_test_code;
		@(posedge pclk) disable iff (!presetn)
		(state_ff == SEQ_SETTLE && lvl_ff == LVL_TEST_HI) |->
			dac_ff == `MDI_DAC_TEST_HI;
	endproperty
	a_test_code: assert property (p_test_code)
		else $error("Test level code wrong");

endmodule : mdi_field_seq

// ### bench/mdi_proc_model.sv
/* Model of the three processor legs, one shared select and enable.
   Assumes a slave that answers on pready; read data is voted 2 of 3. */
`timescale 1ns/1ps

module mdi_proc_model (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic [7:0]       paddr_a,
	output logic [7:0]       paddr_b,
	output logic [7:0]       paddr_c,
	output logic             pwrite_a,
	output logic             pwrite_b,
	output logic             pwrite_c,
	output logic [31:0]      pwdata_a,
	output logic [31:0]      pwdata_b,
	output logic [31:0]      pwdata_c,
	input  wire logic [31:0] prdata_a,
	input  wire logic [31:0] prdata_b,
	input  wire logic [31:0] prdata_c,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// Idle bus at time zero
	initial begin
		{psel, penable, pwrite_a, pwrite_b, pwrite_c} = 5'h0;
		{paddr_a, paddr_b, paddr_c} = 24'h0;
		{pwdata_a, pwdata_b, pwdata_c} = 96'h0;
	end

	// One transfer; bad names the leg sent wrong data (0 for none)
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [1:0] bad,
		output logic [31:0] q, output logic err, output logic ok);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		{paddr_a, pwrite_a, pwdata_a} <= bad == 1 ? ~{a, w, d} : {a, w, d};
		{paddr_b, pwrite_b, pwdata_b} <= bad == 2 ? ~{a, w, d} : {a, w, d};
		{paddr_c, pwrite_c, pwdata_c} <= bad == 3 ? ~{a, w, d} : {a, w, d};
		@(posedge pclk);
		penable <= 1'b1;
		ok = 1'b0;
		for (n = 0; n < 20 && !ok; n++) begin
			@(posedge pclk);
			ok = (pready === 1'b1);
		end
		// Processors vote the three drivers themselves
		q = (prdata_a & prdata_b) | (prdata_a & prdata_c) | (prdata_b & prdata_c);
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released address and data lines must not keep showing the last value
		{paddr_a, paddr_b, paddr_c} <= ~{paddr_a, paddr_b, paddr_c};
		{pwdata_a, pwdata_b, pwdata_c} <= ~{pwdata_a, pwdata_b, pwdata_c};
	endtask : xfer
endmodule : mdi_proc_model

// ### bench/tb_mdi_scan_vote.sv
/* Bench of the scan and vote block: bus, field, self-test, indicators.
   Assumes a point reads high while its voltage code exceeds the DAC. */
`timescale 1ns/1ps
`include "mdi_scan_regs.svh"

module tb_mdi_scan_vote;
	localparam logic [31:0] ID = 32'h0000_3C69; // Arbitrary value
	logic        pclk, presetn, psel, penable, pready, pslverr, e, s;
	logic        pwrite_a, pwrite_b, pwrite_c, drv_en_a, drv_en_b, drv_en_c;
	logic        field_pwr_pin, reg_ok_pin, led_active, led_fault, led_power;
	logic [7:0]  paddr_a, paddr_b, paddr_c, ref_pin, dac_code, vin [16];
	logic [15:0] cmp_pin, led_yellow, led_line;
	logic [31:0] pwdata_a, pwdata_b, pwdata_c, prdata_a, prdata_b, prdata_c, q;
	int          n_fail, n_tests, n;

	// Comparators and reference monitor of the field side
	always_comb begin
		for (int i = 0; i < 16; i++) cmp_pin[i] = vin[i] > dac_code;
	end
	assign ref_pin = dac_code;

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	mdi_scan_vote #(.ID_CODE(ID)) DUT (
		.pclk, .presetn, .psel, .penable, .paddr_a, .paddr_b, .paddr_c,
		.pwrite_a, .pwrite_b, .pwrite_c, .pwdata_a, .pwdata_b, .pwdata_c,
		.prdata_a, .prdata_b, .prdata_c, .drv_en_a, .drv_en_b, .drv_en_c,
		.pready, .pslverr, .cmp_pin, .ref_pin, .field_pwr_pin, .reg_ok_pin,
		.dac_code, .led_yellow, .led_line, .led_active, .led_fault, .led_power);
	mdi_proc_model u_proc (
		.pclk, .psel, .penable, .paddr_a, .paddr_b, .paddr_c, .pwrite_a,
		.pwrite_b, .pwrite_c, .pwdata_a, .pwdata_b, .pwdata_c, .prdata_a,
		.prdata_b, .prdata_c, .pready, .pslverr);

	// ----
	// Tasks
	// ----
	task automatic print_verdict();
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	task automatic chk(input string nm, input logic [31:0] x, y);
		n_tests++;
		if (x !== y) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, x, y);
		end
	endtask : chk
	// A hung transfer counts as a mismatch and ends the run
	task automatic xf(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [1:0] b);
		logic ok;
		u_proc.xfer(w, a, d, b, q, e, ok);
		if (ok !== 1'b1) begin
			n_fail++;
			print_verdict();
		end
	endtask : xf
	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [1:0] b, input logic [31:0] x);
		xf(1'b0, a, 32'h0, b);
		chk(nm, x, q);
	endtask : rdc

	// ----
	// Sequence
	// ----
	initial begin
		presetn = 1'b0;
		field_pwr_pin = 1'b1;
		reg_ok_pin = 1'b1;
		// Point states cycle wire open, switch open, closed, wire short
		for (int i = 0; i < 16; i++) vin[i] = 8'(128 - 32 * (i % 4));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rdc("id", `MDI_REG_ID, 2'd0, ID);
		rdc("thresh", `MDI_REG_THRESH, 2'd0, 32'h0030_5070);
		xf(1'b1, `MDI_REG_LOOP, 32'h1234_ABCD, 2'd2);
		rdc("loop", `MDI_REG_LOOP, 2'd3, 32'h1234_ABCD);
		chk("drv_a", 32'h1234_ABCD, prdata_a);
		chk("drv_c", 32'h1234_ABCD, prdata_c);
		xf(1'b0, 8'h40, 32'h0, 2'd0);
		chk("slverr", 32'h1, {31'h0, e});
		$display("test bus done");
		repeat (3100) @(posedge pclk);
		rdc("onoff", `MDI_REG_INPUT, 2'd0, 32'h0000_CCCC);
		rdc("line", `MDI_REG_LINE, 2'd0, 32'h0000_9999);
		chk("yellow", 32'h0000_CCCC, {16'h0, led_yellow});
		chk("red", 32'h0000_9999, {16'h0, led_line});
		chk("power", 32'h1, {31'h0, led_power});
		s = led_active;
		repeat (1506) @(posedge pclk);
		chk("active", {31'h0, ~s}, {31'h0, led_active});
		$display("test field done");
		xf(1'b1, `MDI_REG_CTRL, 32'h0000_0003, 2'd0);
		q = 32'h0;
		for (n = 0; n < 40 && q[1] !== 1'b1; n++) begin
			repeat (100) @(posedge pclk);
			xf(1'b0, `MDI_REG_STATUS, 32'h0, 2'd0);
		end
		chk("tdone", 32'h2, q & 32'h2);
		chk("legmis", 32'h8, q & 32'h8);
		// Judge by the flag, not the count: a late last poll is still a pass
		if (q[1] !== 1'b1)
			print_verdict();
		rdc("tcmp", `MDI_REG_TCMP, 2'd0, 32'hFFFF_0000);
		rdc("tref", `MDI_REG_TREF, 2'd0, 32'h0000_0CA0);
		chk("red_off", 32'h0, {16'h0, led_line});
		$display("test self-test done");
		// Processors report the fault only after their own filtering
		xf(1'b1, `MDI_REG_CTRL, 32'h0000_0014, 2'd0);
		rdc("drv_bc", `MDI_REG_LOOP, 2'd0, 32'h1234_ABCD);
		chk("drv_a_off", 32'h0, prdata_a);
		chk("drv_en", 32'h6, {29'h0, drv_en_c, drv_en_b, drv_en_a});
		chk("fault", 32'h1, {31'h0, led_fault});
		chk("green", 32'h0, {31'h0, led_active});
		field_pwr_pin <= 1'b0;
		repeat (4) @(posedge pclk);
		chk("power_off", 32'h0, {31'h0, led_power});
		$display("test indicators done");
		print_verdict();
	end
endmodule : tb_mdi_scan_vote
